/* test_user_break_channel_b_control.sv */
// self-checking bench for the two-channel break unit
`timescale 1ns/1ps
module test_user_break_channel_b_control;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg cpu_exception_block_bit = 1'b0;
  reg standby = 1'b0;
  reg rd_strobe = 1'b0;
  logic wr_sel = 1'b0;
  logic [2:0] op_sz = 3'h3;
  wire [31:0] hrdata, acc_addr, acc_data;
  wire [7:0] acc_asid;
  wire [2:0] acc_size;
  wire hreadyout, hresp, acc_valid, acc_is_insn, acc_write;
  wire break_pre_ff, break_post_ff, debug_support_enable_ff;
  logic [63:0] exp_q[$];
  logic [31:0] d, m, base;
  logic [7:0] asid;
  logic [3:0] am [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
  int wv [5] = '{0, 10, 12, 16, 20};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int i;
  always #5 clock = ~clock;
  ubc_core_model u_ubc_core_model (.clock(clock), .acc_valid(acc_valid),
    .acc_is_insn(acc_is_insn), .acc_write(acc_write), .acc_size(acc_size),
    .acc_addr(acc_addr), .acc_asid(acc_asid), .acc_data(acc_data));
  ubc_break_unit u_ubc_break_unit (.clock(clock), .reset_n(reset_n), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acc_valid(acc_valid), .acc_is_insn(acc_is_insn), .acc_write(acc_write),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_asid(acc_asid), .acc_data(acc_data),
    .cpu_exception_block_bit(cpu_exception_block_bit), .standby(standby),
    .break_pre_ff(break_pre_ff), .break_post_ff(break_post_ff),
    .debug_support_enable_ff(debug_support_enable_ff));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task bus(input logic wr, input logic [7:0] off, input logic [31:0] wd,
    input logic [31:0] ev, input logic [31:0] em);
    begin
      haddr <= {24'h0, off};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= wd;
      if (!wr) exp_q.push_back({em, ev});
      rd_strobe <= !wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd_strobe <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] off, input logic [31:0] wd);
    bus(1'b1, off, wd, 32'h0, 32'h0);
  endtask
  task rd(input logic [7:0] off, input logic [31:0] ev);
    bus(1'b0, off, 32'h0, ev, 32'hffff_ffff);
  endtask
  task hit(input logic [1:0] ex, input logic ins, input logic [31:0] ad,
    input logic [7:0] as, input logic [31:0] dat);
    begin
      if (ex != 2'h0) exp_q.push_back({32'h3, 30'h0, ex});
      u_ubc_core_model.issue(ins, wr_sel, ins ? 3'h0 : op_sz, ad, as, dat);
      repeat (2) @(posedge clock);
    end
  endtask
  task note(input logic [31:0] got);
    logic [63:0] e;
    begin
      checks++;
      if (exp_q.size() == 0) e = {32'hffff_ffff, ~got};
      else e = exp_q.pop_front();
      if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, got, e[31:0]);
      end
    end
  endtask
  // result watcher, sampled mid-cycle
  always @(negedge clock) begin
    if (rd_strobe === 1'b1) note(hrdata);
    else if (break_pre_ff !== 1'b0 || break_post_ff !== 1'b0) note({30'h0, break_post_ff, break_pre_ff});
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    d = $urandom(32'h0e11);
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 8'h08, 32'h0, 32'h0, 32'hffff_fb37);
    d = $urandom;
    m = $urandom & 32'hffff_fffe;
    d[15:8] = d[7:0];
    m[15:8] = m[7:0];
    wr(8'h00, d);
    wr(8'h04, m);
    rd(8'h00, d);
    rd(8'h04, m);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_c4c9);
    rd(8'h3c, 32'h0);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(8'h00, d);
    rd(8'h04, m);
    $display("register test done");
    base = $urandom & 32'hffff_fff0;
    asid = $urandom;
    wr(8'h0c, base);
    wr(8'h10, {24'h0, asid});
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h14);
    wr(8'h1c, base ^ 32'h100);
    wr(8'h20, {24'h0, asid});
    wr(8'h24, 32'h0);
    wr(8'h28, 32'h14);
    for (i = 0; i < 4; i++) begin
      wr(8'h08, i[0] ? 32'h440 : 32'h0);
      hit(i[0] ? 2'h2 : 2'h1, 1'b1, base ^ (i[1] ? 32'h100 : 32'h0), asid, 32'h0);
      rd(8'h08, (i[1] ? 32'h4000 : 32'h8000) | (i[0] ? 32'h440 : 32'h0));
    end
    wr(8'h08, 32'h0);
    cpu_exception_block_bit <= 1'b1;
    hit(2'h0, 1'b1, base, asid, 32'h0);
    cpu_exception_block_bit <= 1'b0;
    rd(8'h08, 32'h8000);
    $display("timing test done");
    for (i = 0; i < 5; i++) begin
      wr(8'h14, {28'h0, am[i]});
      hit(2'h0, 1'b1, base ^ (32'h1 << wv[i]), asid, 32'h0);
      if (i > 0) hit(2'h1, 1'b1, base ^ (32'h1 << (wv[i] - 1)), asid, 32'h0);
    end
    wr(8'h14, 32'h3);
    hit(2'h1, 1'b1, base ^ 32'hffff_fffe, asid, 32'h0);
    wr(8'h14, 32'h4);
    hit(2'h1, 1'b1, base, ~asid, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(8'h18, i[0] ? 32'h10 : 32'h04);
      hit(2'h0, 1'b1, base, asid, 32'h0);
    end
    $display("mask test done");
    wr(8'h28, 32'h2f);
    wr(8'h08, 32'h80);
    hit(2'h1, 1'b0, base ^ 32'h100, asid, d ^ ($urandom & m));
    hit(2'h0, 1'b0, base ^ 32'h100, asid, d ^ 32'h1);
    op_sz = 3'h1;
    hit(2'h0, 1'b0, base ^ 32'h100, asid, d);
    wr(8'h28, 32'h2d);
    hit(2'h1, 1'b0, base ^ 32'h100, asid, d);
    op_sz = 3'h3;
    wr_sel = 1'b1;
    wr(8'h28, 32'h27);
    hit(2'h0, 1'b0, base ^ 32'h100, asid, d);
    wr(8'h28, 32'h2b);
    hit(2'h1, 1'b0, base ^ 32'h100, asid, d);
    wr_sel = 1'b0;
    wr(8'h28, 32'h2f);
    wr(8'h08, 32'h0);
    hit(2'h1, 1'b0, base ^ 32'h100, asid, d ^ 32'h1);
    $display("data test done");
    wr(8'h18, 32'h14);
    wr(8'h08, 32'h8);
    hit(2'h0, 1'b1, base, asid, 32'h0);
    hit(2'h1, 1'b0, base ^ 32'h100, asid, 32'h0);
    rd(8'h08, 32'h4008);
    standby <= 1'b1;
    rd(8'h08, 32'h4008);
    wr(8'h08, 32'h0);
    wr(8'h08, 32'h8);
    hit(2'h0, 1'b0, base ^ 32'h100, asid, 32'h0);
    $display("sequence test done");
    repeat (3) @(posedge clock);
    if (exp_q.size() != 0) n_fail++;
    tally_and_finish;
  end
endmodule

/* ubc_break_monitor.sv */
// port checker for the break unit, bound to its top
`timescale 1ns/1ps
module ubc_break_monitor (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hresp,
  // core side and results
  input wire acc_valid,
  input wire acc_is_insn,
  input wire cpu_exception_block_bit,
  input wire break_pre_ff,
  input wire break_post_ff,
  input wire debug_support_enable_ff
);
  reg ap_wr_ff = 1'b0;
  reg ap_rd_ff = 1'b0;
  reg [5:0] ap_off_ff = 6'h00;
  reg [31:0] cmp_ff = 32'h0;
  reg cmp_ok_ff = 1'b0;
  wire take = hsel && hready && htrans[1];
  wire ctrl_wr_dp = ap_wr_ff && ap_off_ff == 6'h02;
  // address phase capture and compare data shadow
  always @(posedge clock) begin
    ap_wr_ff <= reset_n && take && hwrite;
    ap_rd_ff <= reset_n && take && !hwrite;
    ap_off_ff <= haddr[7:2];
    if (ap_wr_ff && ap_off_ff == 6'h00) begin
      cmp_ff <= hwdata;
      cmp_ok_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_ctrl_wr;
    take && hwrite && haddr[7:2] == 6'h02;
  endsequence
  sequence s_ctrl_rd;
    take && !hwrite && haddr[7:2] == 6'h02;
  endsequence
  chk_dbg_follow: assert property (
    s_ctrl_wr ##1 1'b1 |=> debug_support_enable_ff == $past(hwdata[0]))
    else $error("debug enable differs from written bit");
  chk_dbg_hold: assert property (
    $changed(debug_support_enable_ff) |-> $past(ctrl_wr_dp))
    else $error("debug enable moved without a write");
  chk_rsvd_zero: assert property (
    s_ctrl_rd |=> (hrdata & 32'hffff_3b36) == 32'h0)
    else $error("reserved control bits not zero");
  chk_cmp_keep: assert property (
    ap_rd_ff && ap_off_ff == 6'h00 && cmp_ok_ff |-> hrdata == cmp_ff)
    else $error("compare data lost");
  chk_block_quiet: assert property (
    cpu_exception_block_bit |=> !break_pre_ff && !break_post_ff)
    else $error("break while blocked");
  chk_pulse_cause: assert property (
    break_pre_ff || break_post_ff |-> $past(acc_valid))
    else $error("break without an access");
  chk_post_insn: assert property (
    break_post_ff |-> $past(acc_is_insn))
    else $error("post break on operand access");
  chk_one_kind: assert property (
    !(break_pre_ff && break_post_ff))
    else $error("pre and post break together");
  chk_reset_quiet: assert property (
    $rose(reset_n) |-> !debug_support_enable_ff && !break_pre_ff && !break_post_ff)
    else $error("outputs not cleared by reset");
  chk_resp_okay: assert property (
    !hresp)
    else $error("bus response not okay");
endmodule
bind ubc_break_unit ubc_break_monitor u_ubc_break_monitor (.clock(clock), .reset_n(reset_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hresp(hresp), .acc_valid(acc_valid),
  .acc_is_insn(acc_is_insn),
  .cpu_exception_block_bit(cpu_exception_block_bit), .break_pre_ff(break_pre_ff),
  .break_post_ff(break_post_ff), .debug_support_enable_ff(debug_support_enable_ff));

/* ubc_break_unit.v */
// two-channel user break unit with ahb-lite register slave
// Contract
// - channel b compare data is 32-bit read/write, untouched by resets.
// - data mask bit 1 drops that data bit from the compare, 0 keeps it.
// - data mask register is not initialised by any reset.
// - channel a flag bit 15 set on match, cleared by software write or reset.
// - channel b flag bit 14 set on match, stays until software or reset clears.
// - reset clears both flags and debug enable; kept through standby.
// - bit 10 picks channel a instruction break before or after execution.
// - bit 6 picks channel b instruction break before or after execution.
// - bit 7 adds masked data compare to channel b; 0 ignores data.
// - bit 3 selects independent channels or a then b sequence.
// - bit 0 enables debug support function; resets to 0.
// - reserved control bits read as zero; software writes zero.
// - channel b has its own address/asid mask register like channel a.
// - channel b has its own bus-cycle condition register like channel a.
// - mask code masks none, low 10, 12, all, 16, 20 bits; asid bit.
// - access type or read/write selector 00 disables channel compare.
// - match sets flag; break request only while block bit is 0.
// - sequence mode breaks on b after a, setting only the b flag.
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ubc_map.vh"
module ubc_break_unit (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // core access observation
  input wire acc_valid,
  input wire acc_is_insn,
  input wire acc_write,
  input wire [2:0] acc_size,
  input wire [31:0] acc_addr,
  input wire [7:0] acc_asid,
  input wire [31:0] acc_data,
  input wire cpu_exception_block_bit,
  input wire standby,
  // break requests and debug enable
  output reg break_pre_ff,
  output reg break_post_ff,
  output reg debug_support_enable_ff
);
  reg [31:0] chan_b_compare_data_ff;
  reg [31:0] chan_b_data_mask_ff;
  reg [31:0] chan_a_break_address_ff;
  reg [7:0] chan_a_break_asid_ff;
  reg [7:0] chan_a_addr_mask_ff;
  reg [15:0] chan_a_cycle_conditions_ff;
  reg [31:0] chan_b_break_address_ff;
  reg [7:0] chan_b_break_asid_ff;
  reg [7:0] chan_b_addr_mask_ff;
  reg [15:0] chan_b_cycle_conditions_ff;
  reg chan_a_match_flag_ff;
  reg chan_b_match_flag_ff;
  reg chan_a_break_timing_ff;
  reg chan_b_break_timing_ff;
  reg chan_b_data_compare_enable_ff;
  reg chain_mode_select_ff;
  reg chan_a_armed_ff;
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [31:0] nxt_hrdata;
  reg nxt_flag_a;
  reg nxt_flag_b;
  reg nxt_armed;
  reg nxt_break_pre;
  reg nxt_break_post;
  reg break_now;
  reg break_after;
  wire [15:0] break_control_reg;
  wire addr_phase;
  wire [7:0] a_off;
  wire [7:0] w_off;
  wire ctrl_wr;
  wire hit_a;
  wire hit_b;
  assign addr_phase = hsel && hready && (htrans == `UBC_HTRANS_NONSEQ ||
    htrans == `UBC_HTRANS_SEQ);
  assign a_off = {haddr[`UBC_ADDR_MSB:`UBC_ADDR_LSB], 2'b00};
  assign w_off = wr_addr_ff;
  assign ctrl_wr = wr_pend_ff && (w_off == `UBC_OFF_CTRL);
  // reserved bits fixed at zero
  assign break_control_reg = {chan_a_match_flag_ff, chan_b_match_flag_ff, 3'b000,
    chan_a_break_timing_ff, 2'b00, chan_b_data_compare_enable_ff,
    chan_b_break_timing_ff, 2'b00, chain_mode_select_ff, 2'b00,
    debug_support_enable_ff};
  // channel a
  ubc_chan_match u_chan_a (
    .brk_addr(chan_a_break_address_ff),
    .brk_asid(chan_a_break_asid_ff),
    .addr_mask(chan_a_addr_mask_ff),
    .cyc_cond(chan_a_cycle_conditions_ff),
    .data_en(1'b0),
    .cmp_data(`UBC_ZERO32),
    .data_mask(`UBC_ZERO32),
    .acc_valid(acc_valid),
    .acc_is_insn(acc_is_insn),
    .acc_write(acc_write),
    .acc_size(acc_size),
    .acc_addr(acc_addr),
    .acc_asid(acc_asid),
    .acc_data(acc_data),
    .hit(hit_a)
  );
  // channel b with own mask and cycle registers
  ubc_chan_match u_chan_b (
    .brk_addr(chan_b_break_address_ff),
    .brk_asid(chan_b_break_asid_ff),
    .addr_mask(chan_b_addr_mask_ff),
    .cyc_cond(chan_b_cycle_conditions_ff),
    .data_en(chan_b_data_compare_enable_ff),
    .cmp_data(chan_b_compare_data_ff),
    .data_mask(chan_b_data_mask_ff),
    .acc_valid(acc_valid),
    .acc_is_insn(acc_is_insn),
    .acc_write(acc_write),
    .acc_size(acc_size),
    .acc_addr(acc_addr),
    .acc_asid(acc_asid),
    .acc_data(acc_data),
    .hit(hit_b)
  );
  // read mux
  always @* begin
    case (a_off)
      `UBC_OFF_CMP_DATA: nxt_hrdata = chan_b_compare_data_ff;
      `UBC_OFF_DATA_MASK: nxt_hrdata = chan_b_data_mask_ff;
      `UBC_OFF_CTRL: nxt_hrdata = {16'h0000, break_control_reg};
      `UBC_OFF_A_ADDR: nxt_hrdata = chan_a_break_address_ff;
      `UBC_OFF_A_ASID: nxt_hrdata = {24'h000000, chan_a_break_asid_ff};
      `UBC_OFF_A_AMASK: nxt_hrdata = {24'h000000, chan_a_addr_mask_ff};
      `UBC_OFF_A_CYC: nxt_hrdata = {16'h0000, chan_a_cycle_conditions_ff};
      `UBC_OFF_B_ADDR: nxt_hrdata = chan_b_break_address_ff;
      `UBC_OFF_B_ASID: nxt_hrdata = {24'h000000, chan_b_break_asid_ff};
      `UBC_OFF_B_AMASK: nxt_hrdata = {24'h000000, chan_b_addr_mask_ff};
      `UBC_OFF_B_CYC: nxt_hrdata = {16'h0000, chan_b_cycle_conditions_ff};
      default: nxt_hrdata = `UBC_ZERO32;
    endcase
  end
  // match evaluation, chaining and flags
  always @* begin
    nxt_flag_a = chan_a_match_flag_ff;
    nxt_flag_b = chan_b_match_flag_ff;
    nxt_armed = chan_a_armed_ff;
    break_now = 1'b0;
    break_after = 1'b0;
    if (ctrl_wr) begin
      nxt_flag_a = hwdata[`UBC_CTRL_FLAG_A];
      nxt_flag_b = hwdata[`UBC_CTRL_FLAG_B];
      if (!hwdata[`UBC_CTRL_CHAIN]) begin
        nxt_armed = 1'b0;
      end
    end
    if (chain_mode_select_ff) begin
      if (hit_b && chan_a_armed_ff) begin
        nxt_flag_b = 1'b1;
        nxt_armed = 1'b0;
        break_now = 1'b1;
        break_after = acc_is_insn && chan_b_break_timing_ff;
      end else if (hit_a) begin
        nxt_armed = 1'b1;
      end
    end else begin
      nxt_armed = 1'b0;
      if (hit_a) begin
        nxt_flag_a = 1'b1;
        break_now = 1'b1;
        break_after = acc_is_insn && chan_a_break_timing_ff;
      end
      if (hit_b) begin
        nxt_flag_b = 1'b1;
        break_now = 1'b1;
        break_after = break_after || (acc_is_insn && chan_b_break_timing_ff);
      end
    end
    // block bit suppresses exception, flags still set
    nxt_break_pre = break_now && !break_after && !cpu_exception_block_bit;
    nxt_break_post = break_now && break_after && !cpu_exception_block_bit;
  end
  // bus slave and registers
  always @(posedge clock) begin
    if (!reset_n) begin
      hrdata <= `UBC_ZERO32;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      chan_a_cycle_conditions_ff <= `UBC_CYC_RESET;
      chan_b_cycle_conditions_ff <= `UBC_CYC_RESET;
      chan_a_match_flag_ff <= 1'b0;
      chan_b_match_flag_ff <= 1'b0;
      debug_support_enable_ff <= 1'b0;
      chan_a_armed_ff <= 1'b0;
      break_pre_ff <= 1'b0;
      break_post_ff <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_ff <= a_off;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= nxt_hrdata;
      end
      chan_a_match_flag_ff <= nxt_flag_a;
      chan_b_match_flag_ff <= nxt_flag_b;
      chan_a_armed_ff <= nxt_armed;
      break_pre_ff <= nxt_break_pre;
      break_post_ff <= nxt_break_post;
      if (ctrl_wr) begin
        debug_support_enable_ff <= hwdata[`UBC_CTRL_DBG_EN];
      end
      if (wr_pend_ff && w_off == `UBC_OFF_A_CYC) begin
        chan_a_cycle_conditions_ff <= hwdata[15:0] & `UBC_CYC_W_MASK;
      end
      if (wr_pend_ff && w_off == `UBC_OFF_B_CYC) begin
        chan_b_cycle_conditions_ff <= hwdata[15:0] & `UBC_CYC_W_MASK;
      end
    end
  end
  // registers left uninitialised by reset
  always @(posedge clock) begin
    if (wr_pend_ff) begin
      case (w_off)
        `UBC_OFF_CMP_DATA: chan_b_compare_data_ff <= hwdata;
        `UBC_OFF_DATA_MASK: chan_b_data_mask_ff <= hwdata;
        `UBC_OFF_CTRL: begin
          chan_a_break_timing_ff <= hwdata[`UBC_CTRL_TIME_A];
          chan_b_break_timing_ff <= hwdata[`UBC_CTRL_TIME_B];
          chan_b_data_compare_enable_ff <= hwdata[`UBC_CTRL_DATA_EN];
          chain_mode_select_ff <= hwdata[`UBC_CTRL_CHAIN];
        end
        `UBC_OFF_A_ADDR: chan_a_break_address_ff <= hwdata;
        `UBC_OFF_A_ASID: chan_a_break_asid_ff <= hwdata[7:0];
        `UBC_OFF_A_AMASK: chan_a_addr_mask_ff <= hwdata[7:0] & `UBC_AMASK_W_MASK;
        `UBC_OFF_B_ADDR: chan_b_break_address_ff <= hwdata;
        `UBC_OFF_B_ASID: chan_b_break_asid_ff <= hwdata[7:0];
        `UBC_OFF_B_AMASK: chan_b_addr_mask_ff <= hwdata[7:0] & `UBC_AMASK_W_MASK;
        default: chan_b_compare_data_ff <= chan_b_compare_data_ff;
      endcase
    end
  end
endmodule

/* ubc_chan_match.v */
// one break channel: address, asid, cycle type, size and optional data compare
`timescale 1ns/1ps
`include "ubc_map.vh"
module ubc_chan_match (
  // settings
  input wire [31:0] brk_addr,
  input wire [7:0] brk_asid,
  input wire [7:0] addr_mask,
  input wire [15:0] cyc_cond,
  input wire data_en,
  input wire [31:0] cmp_data,
  input wire [31:0] data_mask,
  // observed access
  input wire acc_valid,
  input wire acc_is_insn,
  input wire acc_write,
  input wire [2:0] acc_size,
  input wire [31:0] acc_addr,
  input wire [7:0] acc_asid,
  input wire [31:0] acc_data,
  // result
  output wire hit
);
  wire [2:0] mcode;
  reg [31:0] amask;
  wire [1:0] idsel;
  wire [1:0] rwsel;
  wire [2:0] szsel;
  wire type_ok;
  wire rw_ok;
  wire size_ok;
  wire addr_ok;
  wire asid_ok;
  wire data_ok;
  assign mcode = {addr_mask[3], addr_mask[1], addr_mask[0]};
  always @* begin
    case (mcode)
      3'h0: amask = 32'h0000_0000;
      3'h1: amask = 32'h0000_03ff;
      3'h2: amask = 32'h0000_0fff;
      3'h3: amask = 32'hffff_ffff;
      3'h4: amask = 32'h0000_ffff;
      3'h5: amask = 32'h000f_ffff;
      default: amask = 32'hffff_ffff;
    endcase
  end
  assign idsel = cyc_cond[5:4];
  assign rwsel = cyc_cond[3:2];
  assign szsel = {cyc_cond[6], cyc_cond[1:0]};
  assign type_ok = acc_is_insn ? idsel[0] : idsel[1];
  assign rw_ok = acc_write ? rwsel[1] : rwsel[0];
  assign size_ok = (szsel == 3'h0) || acc_is_insn || (szsel == acc_size);
  assign addr_ok = ((acc_addr ^ brk_addr) & ~amask) == 32'h0000_0000;
  assign asid_ok = addr_mask[2] || (acc_asid == brk_asid);
  // masked data compare, same cycle as address
  assign data_ok = !data_en || acc_is_insn ||
    (((acc_data ^ cmp_data) & ~data_mask) == 32'h0000_0000);
  // 00 in either selector disables the channel
  assign hit = acc_valid && (idsel != 2'b00) && (rwsel != 2'b00) && type_ok && rw_ok &&
    size_ok && addr_ok && asid_ok && data_ok;
endmodule

/* ubc_core_model.sv */
// core model issuing observed fetch and operand cycles
`timescale 1ns/1ps
module ubc_core_model (
  // clock
  input wire clock,
  // observed access
  output reg acc_valid,
  output reg acc_is_insn,
  output reg acc_write,
  output reg [2:0] acc_size,
  output reg [31:0] acc_addr,
  output reg [7:0] acc_asid,
  output reg [31:0] acc_data
);
  initial begin
    acc_valid = 1'b0;
    acc_is_insn = 1'b0;
    acc_write = 1'b0;
    acc_size = 3'h0;
    acc_addr = 32'h0;
    acc_asid = 8'h00;
    acc_data = 32'h0;
  end
  // one access cycle, then the address and data buses show stale inverted values
  task issue(input logic ins, input logic wrt, input logic [2:0] sz, input logic [31:0] ad,
    input logic [7:0] asid, input logic [31:0] dat);
    begin
      @(posedge clock);
      acc_valid <= 1'b1;
      acc_is_insn <= ins;
      acc_write <= wrt;
      acc_size <= sz;
      acc_addr <= ad;
      acc_asid <= asid;
      acc_data <= dat;
      @(posedge clock);
      acc_valid <= 1'b0;
      acc_addr <= ~ad;
      acc_data <= ~dat;
    end
  endtask
endmodule

/* ubc_map.vh */
// register offsets, field positions and reset values for the break unit
`ifndef UBC_MAP_VH
`define UBC_MAP_VH
`define UBC_OFF_CMP_DATA 8'h00
`define UBC_OFF_DATA_MASK 8'h04
`define UBC_OFF_CTRL 8'h08
`define UBC_OFF_A_ADDR 8'h0c
`define UBC_OFF_A_ASID 8'h10
`define UBC_OFF_A_AMASK 8'h14
`define UBC_OFF_A_CYC 8'h18
`define UBC_OFF_B_ADDR 8'h1c
`define UBC_OFF_B_ASID 8'h20
`define UBC_OFF_B_AMASK 8'h24
`define UBC_OFF_B_CYC 8'h28
`define UBC_ADDR_LSB 2
`define UBC_ADDR_MSB 7
`define UBC_CTRL_FLAG_A 15
`define UBC_CTRL_FLAG_B 14
`define UBC_CTRL_TIME_A 10
`define UBC_CTRL_DATA_EN 7
`define UBC_CTRL_TIME_B 6
`define UBC_CTRL_CHAIN 3
`define UBC_CTRL_DBG_EN 0
`define UBC_CTRL_RW_MASK 16'h04c9
`define UBC_ZERO32 32'h0000_0000
`define UBC_ZERO16 16'h0000
`define UBC_AMASK_W_MASK 8'h0f
`define UBC_CYC_W_MASK 16'h007f
`define UBC_CYC_RESET 16'h0000
`define UBC_HTRANS_NONSEQ 2'b10
`define UBC_HTRANS_SEQ 2'b11
`endif
